// >>> thermal_overload_stage.sv
// Purpose : Output, blocking and status logic of the thermal overload stage
// Assumes : Capacity and current values are synchronous and settle between cycles
// Notes   : Program cycle is an internal enable pulse every CYCLE_CLKS clocks
//
// The placing of the registers and strobed register access were chosen for this implementation.
module thermal_overload_stage #(
  parameter int CYCLE_CLKS = thermal_overload_pkg::PROG_CYCLE_CLKS
) (
  input  wire logic                             clk_sys,
  input  wire logic                             reset,
  input  wire logic [7:0]                       reg_addr,
  input  wire logic [31:0]                      reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [31:0]                      reg_rdata,
  input  wire logic [15:0]                      thermal_cap,
  input  wire logic [15:0]                      meas_current,
  input  wire logic [15:0]                      pickup_current,
  input  wire logic                             block_in,
  output logic                                  alarm1,
  output logic                                  alarm2,
  output logic                                  inhibit,
  output logic                                  trip,
  output logic                                  start,
  output logic                                  blocked,
  output thermal_overload_pkg::cond_e           condition,
  output thermal_overload_pkg::node_mode_e      node_mode,
  output logic                                  node_mode_visible,
  output thermal_overload_pkg::load_e           load_status,
  output logic                                  sf_fault,
  output logic                                  amb_fault,
  output logic                                  nom_fault,
  output logic                                  amb_k_fault,
  output logic      [15:0]                      used_service_factor,
  output logic      [15:0]                      used_amb_k,
  output logic      [15:0]                      used_nom_current,
  output logic                                  cycle_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic level_hit(input logic en, input logic [15:0] cap,
                                     input logic [15:0] lvl);
    level_hit = en && (cap >= lvl);
  endfunction : level_hit

  function automatic logic factor_ok(input logic [15:0] f);
    factor_ok = (f >= thermal_overload_pkg::FACTOR_MIN) &&
                (f <= thermal_overload_pkg::FACTOR_MAX);
  endfunction : factor_ok

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers

  logic [6:0]  ctrl;
  logic [15:0] alarm1_lvl;
  logic [15:0] alarm2_lvl;
  logic [15:0] inhib_lvl;
  logic [15:0] trip_lvl;
  logic [19:0] trip_dly;
  logic [15:0] serv_fact;
  logic [15:0] k_max_amb;
  logic [15:0] k_min_amb;
  logic [15:0] nom_curr;
  logic [19:0] trip_cnt;

  // Writes land at once; the next program cycle uses them with no restart
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ctrl       <= thermal_overload_pkg::CTRL_RESET;
      alarm1_lvl <= thermal_overload_pkg::ALARM1_LVL_RESET;
      alarm2_lvl <= thermal_overload_pkg::ALARM2_LVL_RESET;
      inhib_lvl  <= thermal_overload_pkg::INHIB_LVL_RESET;
      trip_lvl   <= thermal_overload_pkg::TRIP_LVL_RESET;
      trip_dly   <= thermal_overload_pkg::TRIP_DLY_RESET;
      serv_fact  <= thermal_overload_pkg::FACTOR_ONE;
      k_max_amb  <= thermal_overload_pkg::FACTOR_ONE;
      k_min_amb  <= thermal_overload_pkg::FACTOR_ONE;
      nom_curr   <= thermal_overload_pkg::NOM_CURR_RESET;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        thermal_overload_pkg::ADDR_CTRL:       ctrl       <= reg_wdata[6:0];
        thermal_overload_pkg::ADDR_ALARM1_LVL: alarm1_lvl <= reg_wdata[15:0];
        thermal_overload_pkg::ADDR_ALARM2_LVL: alarm2_lvl <= reg_wdata[15:0];
        thermal_overload_pkg::ADDR_INHIB_LVL:  inhib_lvl  <= reg_wdata[15:0];
        thermal_overload_pkg::ADDR_TRIP_LVL:   trip_lvl   <= reg_wdata[15:0];
        thermal_overload_pkg::ADDR_TRIP_DLY:
        begin
          // Clamp to the longest settable delay
          if (reg_wdata[19:0] > thermal_overload_pkg::TRIP_DLY_MAX)
            trip_dly <= thermal_overload_pkg::TRIP_DLY_MAX;
          else
            trip_dly <= reg_wdata[19:0];
        end
        thermal_overload_pkg::ADDR_SERV_FACT:  serv_fact  <= reg_wdata[15:0];
        thermal_overload_pkg::ADDR_K_MAX_AMB:  k_max_amb  <= reg_wdata[15:0];
        thermal_overload_pkg::ADDR_K_MIN_AMB:  k_min_amb  <= reg_wdata[15:0];
        thermal_overload_pkg::ADDR_NOM_CURR:   nom_curr   <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  logic en_a1;
  logic en_a2;
  logic en_inh;
  logic en_trip;
  logic [1:0] mode_sel;
  logic stage_off;

  assign en_a1     = ctrl[thermal_overload_pkg::CTRL_EN_ALARM1];
  assign en_a2     = ctrl[thermal_overload_pkg::CTRL_EN_ALARM2];
  assign en_inh    = ctrl[thermal_overload_pkg::CTRL_EN_INHIB];
  assign en_trip   = ctrl[thermal_overload_pkg::CTRL_EN_TRIP];
  assign mode_sel  = ctrl[thermal_overload_pkg::CTRL_MODE_LSB +: 2];
  assign stage_off = (mode_sel == thermal_overload_pkg::MODE_SEL_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Program cycle divider

  logic [$clog2(CYCLE_CLKS)-1:0] div_cnt;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      div_cnt    <= '0;
      cycle_tick <= 1'b0;
    end
    else if (div_cnt == ($clog2(CYCLE_CLKS))'(CYCLE_CLKS - 1))
    begin
      div_cnt    <= '0;
      cycle_tick <= 1'b1;
    end
    else
    begin
      div_cnt    <= div_cnt + 1'b1;
      cycle_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blocking sample and pick-up evaluation

  logic blk_q;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      blk_q <= 1'b0;
    else if (cycle_tick)
      blk_q <= block_in;
  end

  // Evaluation runs in the cycle after the sample, so it always sees this cycle's block
  logic eval;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      eval <= 1'b0;
    else
      eval <= cycle_tick;
  end

  logic hit_a1;
  logic hit_a2;
  logic hit_inh;
  logic hit_trip;
  logic pick;
  logic go;

  assign hit_a1   = level_hit(en_a1, thermal_cap, alarm1_lvl);
  assign hit_a2   = level_hit(en_a2, thermal_cap, alarm2_lvl);
  assign hit_inh  = level_hit(en_inh, thermal_cap, inhib_lvl);
  assign hit_trip = level_hit(en_trip, thermal_cap, trip_lvl);
  assign pick     = !stage_off && (hit_a1 || hit_a2 || hit_inh || hit_trip);
  assign go       = pick && !blk_q;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      start   <= 1'b0;
      blocked <= 1'b0;
    end
    else if (eval)
    begin
      start   <= go;
      blocked <= pick && blk_q;
    end
  end

  // Delay restarts whenever the trip pick-up drops or blocking releases it
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      trip_cnt <= '0;
    else if (eval)
    begin
      if (!(go && hit_trip))
        trip_cnt <= '0;
      else if (trip_cnt < trip_dly)
        trip_cnt <= trip_cnt + 1'b1;
    end
  end

  // Disabling an output drops it at once, not at the next program cycle
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      alarm1  <= 1'b0;
      alarm2  <= 1'b0;
      inhibit <= 1'b0;
      trip    <= 1'b0;
    end
    else
    begin
      if (!en_a1)
        alarm1 <= 1'b0;
      else if (eval)
        alarm1 <= go && hit_a1;
      if (!en_a2)
        alarm2 <= 1'b0;
      else if (eval)
        alarm2 <= go && hit_a2;
      if (!en_inh)
        inhibit <= 1'b0;
      else if (eval)
        inhibit <= go && hit_inh;
      if (!en_trip)
        trip <= 1'b0;
      else if (eval)
        trip <= go && hit_trip && (trip_cnt >= trip_dly);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status reporting

  thermal_overload_pkg::cond_e      next_condition;
  thermal_overload_pkg::node_mode_e next_node_mode;
  thermal_overload_pkg::load_e      next_load;
  logic [31:0] curr_x100;
  logic [16:0] nom_x2;

  always_comb
  begin
    // Condition names the most severe active output
    if (trip)
      next_condition = thermal_overload_pkg::COND_TRIP;
    else if (inhibit)
      next_condition = thermal_overload_pkg::COND_INHIBIT;
    else if (alarm2)
      next_condition = thermal_overload_pkg::COND_ALARM2;
    else if (alarm1)
      next_condition = thermal_overload_pkg::COND_ALARM1;
    else if (blocked)
      next_condition = thermal_overload_pkg::COND_BLOCKED;
    else
      next_condition = thermal_overload_pkg::COND_NORMAL;
  end

  always_comb
  begin
    unique case (mode_sel)
      thermal_overload_pkg::MODE_SEL_ON:
        next_node_mode = blk_q ? thermal_overload_pkg::NODE_BLOCKED
                               : thermal_overload_pkg::NODE_ON;
      thermal_overload_pkg::MODE_SEL_TEST:
        next_node_mode = blk_q ? thermal_overload_pkg::NODE_TEST_BLOCKED
                               : thermal_overload_pkg::NODE_TEST;
      default:
        next_node_mode = thermal_overload_pkg::NODE_OFF;
    endcase
  end

  assign curr_x100 = 32'(meas_current) * 32'd100;
  assign nom_x2    = {used_nom_current, 1'b0};

  always_comb
  begin
    if (curr_x100 < 32'(used_nom_current))
      next_load = thermal_overload_pkg::LOAD_LIGHT;
    else if (17'(meas_current) > nom_x2)
      next_load = thermal_overload_pkg::LOAD_HIGH;
    else if (meas_current > pickup_current)
      next_load = thermal_overload_pkg::LOAD_OVERLOAD;
    else
      next_load = thermal_overload_pkg::LOAD_NORMAL;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      condition         <= thermal_overload_pkg::COND_NORMAL;
      node_mode         <= thermal_overload_pkg::NODE_ON;
      node_mode_visible <= 1'b0;
      load_status       <= thermal_overload_pkg::LOAD_LIGHT;
    end
    else
    begin
      condition         <= next_condition;
      node_mode         <= next_node_mode;
      node_mode_visible <= ctrl[thermal_overload_pkg::CTRL_ALLOW_LN];
      load_status       <= next_load;
    end
  end

  // Fault flags follow the settings and clear as soon as the setting is fixed
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sf_fault            <= 1'b0;
      amb_fault           <= 1'b0;
      nom_fault           <= 1'b0;
      amb_k_fault         <= 1'b0;
      used_service_factor <= thermal_overload_pkg::FACTOR_ONE;
      used_amb_k          <= thermal_overload_pkg::FACTOR_ONE;
      used_nom_current    <= thermal_overload_pkg::NOM_CURR_ONE;
    end
    else
    begin
      sf_fault            <= !factor_ok(serv_fact);
      used_service_factor <= factor_ok(serv_fact) ? serv_fact
                                                  : thermal_overload_pkg::FACTOR_ONE;
      amb_fault           <= !(factor_ok(k_max_amb) && factor_ok(k_min_amb));
      used_amb_k          <= (factor_ok(k_max_amb) && factor_ok(k_min_amb)) ? k_max_amb
                                                  : thermal_overload_pkg::FACTOR_ONE;
      nom_fault           <= (nom_curr == 16'h0000);
      used_nom_current    <= (nom_curr == 16'h0000) ? thermal_overload_pkg::NOM_CURR_ONE
                                                    : nom_curr;
      amb_k_fault         <= (k_min_amb < k_max_amb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        thermal_overload_pkg::ADDR_CTRL:       reg_rdata <= {25'h0, ctrl};
        thermal_overload_pkg::ADDR_ALARM1_LVL: reg_rdata <= {16'h0, alarm1_lvl};
        thermal_overload_pkg::ADDR_ALARM2_LVL: reg_rdata <= {16'h0, alarm2_lvl};
        thermal_overload_pkg::ADDR_INHIB_LVL:  reg_rdata <= {16'h0, inhib_lvl};
        thermal_overload_pkg::ADDR_TRIP_LVL:   reg_rdata <= {16'h0, trip_lvl};
        thermal_overload_pkg::ADDR_TRIP_DLY:   reg_rdata <= {12'h0, trip_dly};
        thermal_overload_pkg::ADDR_SERV_FACT:  reg_rdata <= {16'h0, serv_fact};
        thermal_overload_pkg::ADDR_K_MAX_AMB:  reg_rdata <= {16'h0, k_max_amb};
        thermal_overload_pkg::ADDR_K_MIN_AMB:  reg_rdata <= {16'h0, k_min_amb};
        thermal_overload_pkg::ADDR_NOM_CURR:   reg_rdata <= {16'h0, nom_curr};
        thermal_overload_pkg::ADDR_STATUS:
          reg_rdata <= {13'h0, amb_k_fault, nom_fault, amb_fault, sf_fault,
                        load_status, node_mode_visible,
                        node_mode_visible ? node_mode : thermal_overload_pkg::NODE_ON,
                        condition, blocked, start, trip, inhibit, alarm2, alarm1};
        thermal_overload_pkg::ADDR_TRIP_CNT:   reg_rdata <= {12'h0, trip_cnt};
        default:                               reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_alarm1_sets: assert property (@(posedge clk_sys) disable iff (reset)
    eval && go && hit_a1 |=> alarm1)
    else $error("alarm 1 missed its threshold");
  a_alarm2_sets: assert property (@(posedge clk_sys) disable iff (reset)
    eval && go && hit_a2 |=> alarm2)
    else $error("alarm 2 missed its threshold");
  a_inhibit_level: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(inhibit) |-> $past(thermal_cap) >= $past(inhib_lvl))
    else $error("inhibit rose below its threshold");
  a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    (alarm1 |-> $past(en_a1)) and (trip |-> $past(en_trip)))
    else $error("disabled output asserted");
  a_trip_delay: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(trip) |-> $past(trip_cnt) >= $past(trip_dly))
    else $error("trip came before its delay");
  a_block_sample: assert property (@(posedge clk_sys) disable iff (reset)
    cycle_tick |=> blk_q == $past(block_in))
    else $error("blocking not sampled at cycle start");
  a_blocked_pick: assert property (@(posedge clk_sys) disable iff (reset)
    eval && pick && blk_q |=> blocked && !start && !alarm1 && !trip)
    else $error("blocked pick-up was processed");
  a_block_release: assert property (@(posedge clk_sys) disable iff (reset)
    start && eval && blk_q |=> !start ##0 trip_cnt == 20'h0_0000)
    else $error("start survived blocking");
  a_normal_idle: assert property (@(posedge clk_sys) disable iff (reset)
    condition == thermal_overload_pkg::COND_NORMAL |->
      !$past(alarm1) && !$past(alarm2) && !$past(inhibit) && !$past(trip))
    else $error("normal code with an output active");
  a_light_load: assert property (@(posedge clk_sys) disable iff (reset)
    curr_x100 < 32'(used_nom_current) |=> load_status == thermal_overload_pkg::LOAD_LIGHT)
    else $error("light load not reported");
  a_sf_fallback: assert property (@(posedge clk_sys) disable iff (reset)
    !factor_ok(serv_fact) |=> sf_fault && used_service_factor == 16'h0064)
    else $error("service factor fault not handled");

  c_trip_delayed: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(trip) && trip_dly != 20'h0_0000);
  c_blocked: cover property (@(posedge clk_sys) disable iff (reset) $rose(blocked));
  c_release: cover property (@(posedge clk_sys) disable iff (reset) start ##1 !start);
  c_all_out: cover property (@(posedge clk_sys) disable iff (reset)
    alarm1 && alarm2 && inhibit && trip);

endmodule : thermal_overload_stage

// >>> thermal_overload_pkg.sv
// Purpose : Shared constants and types of the thermal overload output stage
// Assumes : Thermal capacity and thresholds in 0.1 % units, currents in 0.001 x In
// Notes   : Register offsets are byte addresses of 32-bit words
package thermal_overload_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_ALARM1_LVL = 8'h04;
  localparam logic [7:0] ADDR_ALARM2_LVL = 8'h08;
  localparam logic [7:0] ADDR_INHIB_LVL  = 8'h0c;
  localparam logic [7:0] ADDR_TRIP_LVL   = 8'h10;
  localparam logic [7:0] ADDR_TRIP_DLY   = 8'h14;
  localparam logic [7:0] ADDR_SERV_FACT  = 8'h18;
  localparam logic [7:0] ADDR_K_MAX_AMB  = 8'h1c;
  localparam logic [7:0] ADDR_K_MIN_AMB  = 8'h20;
  localparam logic [7:0] ADDR_NOM_CURR   = 8'h24;
  localparam logic [7:0] ADDR_STATUS     = 8'h28;
  localparam logic [7:0] ADDR_TRIP_CNT   = 8'h2c;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_EN_ALARM1 = 0;
  localparam int CTRL_EN_ALARM2 = 1;
  localparam int CTRL_EN_INHIB  = 2;
  localparam int CTRL_EN_TRIP   = 3;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_ALLOW_LN  = 6;
  localparam int CTRL_WIDTH     = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  localparam logic [1:0] MODE_SEL_ON   = 2'h0;
  localparam logic [1:0] MODE_SEL_TEST = 2'h1;
  localparam logic [1:0] MODE_SEL_OFF  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values (0.1 % steps, delay in 5 ms program cycles, factors x100)
  localparam logic [15:0] ALARM1_LVL_RESET = 16'h0190;
  localparam logic [15:0] ALARM2_LVL_RESET = 16'h0190;
  localparam logic [15:0] INHIB_LVL_RESET  = 16'h0320;
  localparam logic [15:0] TRIP_LVL_RESET   = 16'h03e8;
  localparam logic [19:0] TRIP_DLY_RESET   = 20'h0_0000;
  localparam logic [19:0] TRIP_DLY_MAX     = 20'hA_FC80;
  localparam logic [15:0] FACTOR_ONE       = 16'h0064;
  localparam logic [15:0] FACTOR_MIN       = 16'h0001;
  localparam logic [15:0] FACTOR_MAX       = 16'h01f4;
  localparam logic [15:0] NOM_CURR_RESET   = 16'h03e8;
  localparam logic [15:0] NOM_CURR_ONE     = 16'h03e8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int PROG_CYCLE_US = 5000;
  localparam int PROG_CYCLE_CLKS = (CLK_HZ / 1_000_000) * PROG_CYCLE_US;
  localparam int BLOCK_LEAD_MS = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Status codes
  typedef enum logic [2:0] {COND_NORMAL, COND_ALARM1, COND_ALARM2, COND_INHIBIT,
                            COND_TRIP, COND_BLOCKED} cond_e;
  typedef enum logic [2:0] {NODE_ON, NODE_BLOCKED, NODE_TEST, NODE_TEST_BLOCKED,
                            NODE_OFF} node_mode_e;
  typedef enum logic [1:0] {LOAD_LIGHT, LOAD_NORMAL, LOAD_OVERLOAD,
                            LOAD_HIGH} load_e;

endpackage : thermal_overload_pkg

// >>> block_matrix_model.sv
// Purpose: Blocking source in front of the stage
// Assumes: Request is taken at cycle starts only
// Notes  : Lead of one whole program cycle before use
module block_matrix_model (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic cycle_tick,
  input  wire logic req,
  output logic      block_in
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      block_in <= 1'b0;
    else if (cycle_tick)
      block_in <= req;
  end
endmodule : block_matrix_model

// >>> tb_thermal_overload_stage.sv
// Purpose: Random self-check of the overload stage
// Assumes: Short program cycle of 8 clocks
// Notes  : Bench model recomputes every evaluation
module tb_thermal_overload_stage;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, req = 0, block_in;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic [15:0] thermal_cap = 16'h0000, meas_current = 16'h0000;
  logic [15:0] pickup_current = 16'h044c;
  logic alarm1, alarm2, inhibit, trip, start, blocked, node_mode_visible;
  logic sf_fault, amb_fault, nom_fault, amb_k_fault, cycle_tick;
  logic [15:0] used_service_factor, used_amb_k, used_nom_current;
  thermal_overload_pkg::cond_e condition;
  thermal_overload_pkg::node_mode_e node_mode;
  thermal_overload_pkg::load_e load_status;
  int n_mismatch = 0, checks = 0, cnt = 0, dly = 0, ce, cl, nm, md;
  int lv[4] = '{400, 400, 800, 1000};
  int unsigned seed = 30;
  logic [3:0] en, hit, o;
  logic b, pk, st;
  localparam logic [7:0] RA[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h30};
  localparam logic [15:0] RV[7] = '{16'h0000, 16'h0190, 16'h0190, 16'h0320,
                                   16'h03e8, 16'h0000, 16'h0000};
  always #10 clk_sys = ~clk_sys;
  thermal_overload_stage #(.CYCLE_CLKS(8)) i_dut (.clk_sys, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .thermal_cap, .meas_current,
    .pickup_current, .block_in, .alarm1, .alarm2, .inhibit, .trip, .start,
    .blocked, .condition, .node_mode, .node_mode_visible, .load_status,
    .sf_fault, .amb_fault, .nom_fault, .amb_k_fault, .used_service_factor,
    .used_amb_k, .used_nom_current, .cycle_tick);
  block_matrix_model i_blk (.clk_sys, .reset, .cycle_tick, .req, .block_in);
  ////////////////////////////////////////////////////////////////////////////
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Gap cycle keeps the strobe from being driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= {16'h0000, v};
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  task automatic end_sim();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500_000;
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++)
    begin
      rd(RA[i]);
      chk(d, RV[i]);
    end
    wr(8'h18, 16'h0000);
    wr(8'h1c, 16'h0000);
    wr(8'h24, 16'h0000);
    #1 chk({sf_fault, amb_fault, nom_fault, amb_k_fault}, 4'b1110);
    chk({used_service_factor, used_amb_k, used_nom_current}, 48'h0064_0064_03e8);
    wr(8'h18, 16'h00fa);
    wr(8'h1c, 16'h00c8);
    wr(8'h24, 16'h03e8);
    #1 chk({sf_fault, amb_fault, nom_fault, amb_k_fault}, 4'b0001);
    chk({used_service_factor, used_amb_k, used_nom_current}, 48'h00fa_00c8_03e8);
    wr(8'h1c, 16'h0064);
    for (int i = 0; i < 60; i++)
    begin
      if (i % 8 == 0)
      begin
        // Idle program cycle under the setting writes, so both delay counts restart
        thermal_cap <= 16'h0000;
        cnt = 0;
        lv[3] = 600 + xs() % 400;
        dly = xs() % 3;
        wr(8'h10, lv[3][15:0]);
        wr(8'h14, dly[15:0]);
      end
      en = xs() % 16;
      md = xs() % 3;
      wr(8'h00, {9'h000, 1'b1, md[1:0], en});
      thermal_cap <= 300 + xs() % 900;
      meas_current <= (xs() % 4 == 0) ? xs() % 20 : xs() % 2600;
      req <= (xs() % 4 == 0);
      do @(negedge clk_sys); while (cycle_tick !== 1'b1);
      b = block_in;
      for (int k = 0; k < 4; k++)
        hit[k] = thermal_cap >= lv[k];
      pk = (md != 2) && |(en & hit);
      st = pk & !b;
      o = en & hit & {4{st}};
      if (o[3])
      begin
        o[3] = cnt >= dly;
        cnt++;
      end
      else
        cnt = 0;
      nm = (md == 2) ? 4 : 2 * md + b;
      repeat (3) @(posedge clk_sys);
      #1 chk({trip, inhibit, alarm2, alarm1, start, blocked}, {o, st, pk & b});
      cl = meas_current * 100 < 1000 ? 0 : meas_current > 2000 ? 3 :
           meas_current > pickup_current ? 2 : 1;
      chk(load_status, cl);
      chk(node_mode_visible, 1'b1);
      chk(node_mode, nm);
      ce = o[3] ? 4 : o[2] ? 3 : o[1] ? 2 : o[0] ? 1 : pk & b ? 5 : 0;
      @(posedge clk_sys);
      #1 chk(condition, ce);
      rd(8'h28);
      chk(d, {13'h0, 4'h0, cl[1:0], 1'b1, nm[2:0], ce[2:0], pk & b, st, o});
    end
    end_sim();
  end
endmodule : tb_thermal_overload_stage
